// >>> hdl/ssrs_sequencer.sv
// power-down and reconfiguration control behind the serial register port
`timescale 1ns/1ps
`default_nettype none
module ssrs_sequencer #(
  parameter logic [3:0] BLACK_SETTLE_FRAMES = ssrs_pkg::BLACK_SETTLE_FRAMES,
  parameter int MEM_DEPTH = 512
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // serial register port
  input wire logic SPI_CLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_MOSI_IN,
  output logic SPI_MISO_OUT,
  // frame timing from the readout
  input wire logic FRAME_START_IN,
  // state and acquisition
  output logic [1:0] SENSOR_STATE_OUT,
  output logic SEQ_ENABLE_OUT,
  output logic IMAGE_ACTIVE_OUT,
  output logic [5:0] OP_MODE_OUT,
  // block enables
  output logic TX_ENABLE_OUT,
  output logic AFE_ENABLE_OUT,
  output logic COLUMN_MUX_ENABLE_OUT,
  output logic CHARGE_PUMP_ENABLE_OUT,
  output logic BIAS_ENABLE_OUT,
  output logic LOGIC_BLOCK_ENABLE_OUT,
  output logic LOGIC_CLOCK_ENABLE_OUT,
  output logic PLL_ENABLE_OUT,
  // soft resets
  output logic CORE_SOFT_RESET_OUT,
  output logic CLKGEN_SOFT_RESET_OUT,
  output logic PLL_SOFT_RESET_OUT,
  // reconfiguration side effects
  output logic STATIC_FAULT_OUT,
  output logic BLACK_CAL_TRANSIENT_OUT,
  output logic SYNC_CODE_TRANSIENT_OUT,
  output logic TEST_PATTERN_TRANSIENT_OUT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic is_write;
    logic [8:0] addr;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic miso;
    logic mem_wr;
    logic [15:0] mem_wdata;
    logic [15:0] pll_rst;
    logic [15:0] clkgen_rst;
    logic [15:0] core_rst;
    logic [15:0] pll_pwr;
    logic [15:0] clk_mgmt;
    logic [15:0] clk_dist;
    logic [15:0] logic_en;
    logic [15:0] colmux;
    logic [15:0] afe;
    logic [15:0] bias;
    logic [15:0] cpump;
    logic [15:0] tx;
    logic [15:0] seq_mode;
    ssrs_pkg::ssrs_state_e state;
    logic static_fault;
    logic [3:0] black_cnt;
    logic sync_dirty;
    logic tp_dirty;
    logic [18:0] outs;
  } ssrs_state_s;

  ssrs_state_s r;
  ssrs_state_s n;

  ssrs_mem_if #(.AW(ssrs_pkg::ADDR_W), .DW(ssrs_pkg::DATA_W)) mem_bus ();

  ssrs_reg_mem #(.DEPTH(MEM_DEPTH)) u_mem (
    .clk_in(SYS_CLK_IN),
    .resetn_in(RESETN_IN),
    .bus(mem_bus.mem)
  );

  assign mem_bus.wr_en = r.mem_wr;
  assign mem_bus.addr = r.addr;
  assign mem_bus.wdata = r.mem_wdata;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo, input logic [8:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_static(input logic [8:0] a);
    is_static = (a == ssrs_pkg::OFS_CLOCK_DISTRIBUTION_CFG) || (a == ssrs_pkg::OFS_COLUMN_MUX_ENABLE)
      || (a == ssrs_pkg::OFS_FRONT_END_ENABLE) || (a == ssrs_pkg::OFS_SERIAL_TRANSMITTER_CTRL)
      || in_range(a, ssrs_pkg::OFS_BIAS_ENABLE, ssrs_pkg::OFS_BIAS_GROUP_LAST);
  endfunction

  // tracked registers answer from their flops, the rest from memory
  function automatic logic [15:0] read_word(input ssrs_state_s s, input logic [15:0] mem_word);
    case (s.addr)
      ssrs_pkg::OFS_PLL_SOFT_RESET_CTRL: read_word = s.pll_rst;
      ssrs_pkg::OFS_CLOCK_GENERATOR_RESET_CTRL: read_word = s.clkgen_rst;
      ssrs_pkg::OFS_CORE_SOFT_RESET_CTRL: read_word = s.core_rst;
      ssrs_pkg::OFS_PLL_POWER_CTRL: read_word = s.pll_pwr;
      ssrs_pkg::OFS_CLOCK_MANAGEMENT_CFG: read_word = s.clk_mgmt;
      ssrs_pkg::OFS_CLOCK_DISTRIBUTION_CFG: read_word = s.clk_dist;
      ssrs_pkg::OFS_LOGIC_BLOCK_ENABLE: read_word = s.logic_en;
      ssrs_pkg::OFS_COLUMN_MUX_ENABLE: read_word = s.colmux;
      ssrs_pkg::OFS_FRONT_END_ENABLE: read_word = s.afe;
      ssrs_pkg::OFS_BIAS_ENABLE: read_word = s.bias;
      ssrs_pkg::OFS_CHARGE_PUMP_CTRL: read_word = s.cpump;
      ssrs_pkg::OFS_SERIAL_TRANSMITTER_CTRL: read_word = s.tx;
      ssrs_pkg::OFS_SEQUENCER_MODE_CTRL: read_word = s.seq_mode;
      default: read_word = mem_word;
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic sclk_rise;
  logic sclk_fall;
  logic commit;
  logic [15:0] wdata;
  logic running;
  logic clock_on;
  logic powered;
  logic [15:0] rword;

  always_comb begin
    n = r;
    n.mem_wr = 1'b0;
    n.sclk_q = SPI_CLK_IN;
    sclk_rise = SPI_CLK_IN && !r.sclk_q;
    sclk_fall = !SPI_CLK_IN && r.sclk_q;
    commit = 1'b0;
    wdata = {r.shift_in[14:0], SPI_MOSI_IN};
    running = (r.state == ssrs_pkg::ST_RUNNING);
    rword = read_word(r, mem_bus.rdata);

    // serial frame: write flag, 9 address bits, 16 data bits, msb first
    if (SPI_CS_N_IN) begin
      n.bit_cnt = 5'h00;
      n.miso = 1'b0;
    end else if (sclk_rise && (r.bit_cnt <= ssrs_pkg::BIT_FRAME_LAST)) begin
      n.bit_cnt = r.bit_cnt + 5'h01;
      n.shift_in = wdata;
      if (r.bit_cnt == ssrs_pkg::BIT_WR_FLAG) begin
        n.is_write = SPI_MOSI_IN;
      end else if (r.bit_cnt <= ssrs_pkg::BIT_ADDR_LAST) begin
        n.addr = {r.addr[7:0], SPI_MOSI_IN};
      end
      commit = r.is_write && (r.bit_cnt == ssrs_pkg::BIT_FRAME_LAST);
    end else if (sclk_fall && !r.is_write && (r.bit_cnt >= ssrs_pkg::BIT_DATA_FIRST)) begin
      if (r.bit_cnt == ssrs_pkg::BIT_DATA_FIRST) begin
        n.miso = rword[15];
        n.shift_out = {rword[14:0], 1'b0};
      end else begin
        n.miso = r.shift_out[15];
        n.shift_out = {r.shift_out[14:0], 1'b0};
      end
    end

    // ----------------------------------------
    // register writes; every write lands, whatever the state
    // ----------------------------------------
    if (commit) begin
      n.mem_wr = 1'b1;
      n.mem_wdata = wdata;
      case (r.addr)
        ssrs_pkg::OFS_PLL_SOFT_RESET_CTRL: n.pll_rst = wdata;
        ssrs_pkg::OFS_CLOCK_GENERATOR_RESET_CTRL: n.clkgen_rst = wdata;
        ssrs_pkg::OFS_CORE_SOFT_RESET_CTRL: n.core_rst = wdata;
        ssrs_pkg::OFS_PLL_POWER_CTRL: n.pll_pwr = wdata;
        ssrs_pkg::OFS_CLOCK_MANAGEMENT_CFG: n.clk_mgmt = wdata;
        ssrs_pkg::OFS_CLOCK_DISTRIBUTION_CFG: n.clk_dist = wdata;
        ssrs_pkg::OFS_LOGIC_BLOCK_ENABLE: n.logic_en = wdata;
        ssrs_pkg::OFS_COLUMN_MUX_ENABLE: n.colmux = wdata;
        ssrs_pkg::OFS_FRONT_END_ENABLE: n.afe = wdata;
        ssrs_pkg::OFS_BIAS_ENABLE: n.bias = wdata;
        ssrs_pkg::OFS_CHARGE_PUMP_CTRL: n.cpump = wdata;
        ssrs_pkg::OFS_SERIAL_TRANSMITTER_CTRL: n.tx = wdata;
        ssrs_pkg::OFS_SEQUENCER_MODE_CTRL: n.seq_mode = wdata;
        default: n.mem_wdata = wdata;
      endcase
    end

    // ----------------------------------------
    // reconfiguration side effects while acquiring
    // ----------------------------------------
    if (FRAME_START_IN) begin
      n.sync_dirty = 1'b0;
      n.tp_dirty = 1'b0;
      if (r.black_cnt != 4'h0) begin
        n.black_cnt = r.black_cnt - 4'h1;
      end
    end
    if (!running) begin
      n.static_fault = 1'b0;
    end
    // sets come after the clears so a same-cycle event is kept
    if (commit && running) begin
      if (is_static(r.addr) || ((r.addr == ssrs_pkg::OFS_SEQUENCER_MODE_CTRL)
          && (wdata[ssrs_pkg::MODE_MSB:ssrs_pkg::MODE_LSB]
              != r.seq_mode[ssrs_pkg::MODE_MSB:ssrs_pkg::MODE_LSB]))) begin
        n.static_fault = 1'b1;
      end
      if (in_range(r.addr, ssrs_pkg::OFS_BLACK_FIRST, ssrs_pkg::OFS_BLACK_LAST)
          || (r.addr == ssrs_pkg::OFS_BLACK_LINES)) begin
        n.black_cnt = BLACK_SETTLE_FRAMES;
      end
      if (in_range(r.addr, ssrs_pkg::OFS_BLACK_LAST, ssrs_pkg::OFS_SYNC_CODE_LAST)) begin
        n.sync_dirty = 1'b1;
      end
      if (in_range(r.addr, ssrs_pkg::OFS_TEST_PATTERN_FIRST, ssrs_pkg::OFS_TEST_PATTERN_LAST)) begin
        n.tp_dirty = 1'b1;
      end
    end

    // ----------------------------------------
    // sensor state follows the register image
    // ----------------------------------------
    clock_on = (n.clkgen_rst == 16'h0000) && n.clk_dist[ssrs_pkg::LOGIC_CLOCK_BIT];
    powered = (n.core_rst == 16'h0000) && n.bias[0] && (|n.cpump[1:0]) && (|n.colmux[1:0]) && n.afe[0];
    case (r.state)
      ssrs_pkg::ST_CLOCK_OFF: begin
        if (clock_on) begin
          n.state = ssrs_pkg::ST_STANDBY;
        end
      end
      ssrs_pkg::ST_STANDBY: begin
        if (!clock_on) begin
          n.state = ssrs_pkg::ST_CLOCK_OFF;
        end else if (powered) begin
          n.state = ssrs_pkg::ST_IDLE;
        end
      end
      ssrs_pkg::ST_IDLE: begin
        if (!powered || !clock_on) begin
          n.state = ssrs_pkg::ST_STANDBY;
        end else if (n.seq_mode[ssrs_pkg::SEQ_ENABLE_BIT]) begin
          n.state = ssrs_pkg::ST_RUNNING;
        end
      end
      ssrs_pkg::ST_RUNNING: begin
        // artifact-prone rewrites stay in this state unless they drop power, the logic clock or the enable bit
        if (!powered || !clock_on) begin
          n.state = ssrs_pkg::ST_STANDBY;
        end else if (!n.seq_mode[ssrs_pkg::SEQ_ENABLE_BIT]) begin
          n.state = ssrs_pkg::ST_IDLE;
        end
      end
      default: n.state = ssrs_pkg::ST_CLOCK_OFF;
    endcase

    // registered output image, built from the next register values
    n.outs = {
      (n.state == ssrs_pkg::ST_RUNNING),
      n.tx[2:0] != 3'h0,
      n.afe[0],
      n.colmux[1:0] != 2'h0,
      n.cpump[1:0] != 2'h0,
      n.bias[0],
      n.logic_en[0],
      n.clk_dist[ssrs_pkg::LOGIC_CLOCK_BIT],
      n.pll_pwr[0],
      n.core_rst != 16'h0000,
      n.clkgen_rst != 16'h0000,
      n.pll_rst != 16'h0000,
      n.black_cnt != 4'h0,
      n.seq_mode[ssrs_pkg::MODE_MSB:ssrs_pkg::MODE_LSB]
    };
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= '{
        sclk_q: 1'b0,
        bit_cnt: 5'h00,
        is_write: 1'b0,
        addr: 9'h000,
        shift_in: 16'h0000,
        shift_out: 16'h0000,
        miso: 1'b0,
        mem_wr: 1'b0,
        mem_wdata: 16'h0000,
        pll_rst: ssrs_pkg::RST_PLL_SOFT_RESET_CTRL,
        clkgen_rst: ssrs_pkg::RST_CLOCK_GENERATOR_RESET_CTRL,
        core_rst: ssrs_pkg::RST_CORE_SOFT_RESET_CTRL,
        pll_pwr: ssrs_pkg::RST_ZERO,
        clk_mgmt: ssrs_pkg::RST_ZERO,
        clk_dist: ssrs_pkg::RST_CLOCK_DISTRIBUTION_CFG,
        logic_en: ssrs_pkg::RST_ZERO,
        colmux: ssrs_pkg::RST_ZERO,
        afe: ssrs_pkg::RST_ZERO,
        bias: ssrs_pkg::RST_ZERO,
        cpump: ssrs_pkg::RST_CHARGE_PUMP_CTRL,
        tx: ssrs_pkg::RST_ZERO,
        seq_mode: ssrs_pkg::RST_ZERO,
        state: ssrs_pkg::ST_CLOCK_OFF,
        static_fault: 1'b0,
        black_cnt: 4'h0,
        sync_dirty: 1'b0,
        tp_dirty: 1'b0,
        outs: 19'h00000
      };
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign SPI_MISO_OUT = r.miso;
  assign SENSOR_STATE_OUT = r.state;
  assign SEQ_ENABLE_OUT = r.seq_mode[ssrs_pkg::SEQ_ENABLE_BIT];
  assign IMAGE_ACTIVE_OUT = r.outs[18];
  assign TX_ENABLE_OUT = r.outs[17];
  assign AFE_ENABLE_OUT = r.outs[16];
  assign COLUMN_MUX_ENABLE_OUT = r.outs[15];
  assign CHARGE_PUMP_ENABLE_OUT = r.outs[14];
  assign BIAS_ENABLE_OUT = r.outs[13];
  assign LOGIC_BLOCK_ENABLE_OUT = r.outs[12];
  assign LOGIC_CLOCK_ENABLE_OUT = r.outs[11];
  assign PLL_ENABLE_OUT = r.outs[10];
  assign CORE_SOFT_RESET_OUT = r.outs[9];
  assign CLKGEN_SOFT_RESET_OUT = r.outs[8];
  assign PLL_SOFT_RESET_OUT = r.outs[7];
  assign BLACK_CAL_TRANSIENT_OUT = r.outs[6];
  assign OP_MODE_OUT = r.outs[5:0];
  assign STATIC_FAULT_OUT = r.static_fault;
  assign SYNC_CODE_TRANSIENT_OUT = r.sync_dirty;
  assign TEST_PATTERN_TRANSIENT_OUT = r.tp_dirty;
endmodule
`default_nettype wire

// >>> hdl/ssrs_pkg.sv
// constants for the sensor shutdown and reconfiguration sequencer
package ssrs_pkg;
  // ----------------------------------------
  // serial access frame
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam logic [4:0] BIT_WR_FLAG = 5'h00;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h09;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h0A;
  localparam logic [4:0] BIT_FRAME_LAST = 5'h19;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [8:0] OFS_PLL_SOFT_RESET_CTRL = 9'h008;
  localparam logic [8:0] OFS_CLOCK_GENERATOR_RESET_CTRL = 9'h009;
  localparam logic [8:0] OFS_CORE_SOFT_RESET_CTRL = 9'h00A;
  localparam logic [8:0] OFS_PLL_POWER_CTRL = 9'h010;
  localparam logic [8:0] OFS_CLOCK_MANAGEMENT_CFG = 9'h014;
  localparam logic [8:0] OFS_CLOCK_DISTRIBUTION_CFG = 9'h020;
  localparam logic [8:0] OFS_LOGIC_BLOCK_ENABLE = 9'h022;
  localparam logic [8:0] OFS_COLUMN_MUX_ENABLE = 9'h028;
  localparam logic [8:0] OFS_FRONT_END_ENABLE = 9'h030;
  localparam logic [8:0] OFS_BIAS_ENABLE = 9'h040;
  localparam logic [8:0] OFS_CHARGE_PUMP_CTRL = 9'h048;
  localparam logic [8:0] OFS_SERIAL_TRANSMITTER_CTRL = 9'h070;
  localparam logic [8:0] OFS_SEQUENCER_MODE_CTRL = 9'h0C0;
  // address groups
  localparam logic [8:0] OFS_BIAS_GROUP_LAST = 9'h047;
  localparam logic [8:0] OFS_BLACK_FIRST = 9'h080;
  localparam logic [8:0] OFS_BLACK_LAST = 9'h081;
  localparam logic [8:0] OFS_SYNC_CODE_FIRST = 9'h082;
  localparam logic [8:0] OFS_SYNC_CODE_LAST = 9'h087;
  localparam logic [8:0] OFS_TEST_PATTERN_FIRST = 9'h090;
  localparam logic [8:0] OFS_TEST_PATTERN_LAST = 9'h096;
  localparam logic [8:0] OFS_BLACK_LINES = 9'h0C5;
  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int SEQ_ENABLE_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 6;
  localparam int LOGIC_CLOCK_BIT = 1;
  localparam int SYNC_WIDTH_BIT = 13;
  localparam int BLACK_LINE_CAL_BIT = 8;
  localparam logic [15:0] CORE_SOFT_RESET_VALUE = 16'h0999;
  localparam logic [15:0] CLKGEN_SOFT_RESET_VALUE = 16'h0009;
  localparam logic [15:0] PLL_SOFT_RESET_VALUE = 16'h0099;
  // ----------------------------------------
  // reset values: everything held off and in soft reset
  // ----------------------------------------
  localparam logic [15:0] RST_PLL_SOFT_RESET_CTRL = 16'h0099;
  localparam logic [15:0] RST_CLOCK_GENERATOR_RESET_CTRL = 16'h0009;
  localparam logic [15:0] RST_CORE_SOFT_RESET_CTRL = 16'h0999;
  localparam logic [15:0] RST_CLOCK_DISTRIBUTION_CFG = 16'h2000;
  localparam logic [15:0] RST_CHARGE_PUMP_CTRL = 16'h0200;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [3:0] BLACK_SETTLE_FRAMES = 4'h4;
  // ----------------------------------------
  // sensor states, gray coded along off-standby-idle-running
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_CLOCK_OFF = 2'b00,
    ST_STANDBY = 2'b01,
    ST_IDLE = 2'b11,
    ST_RUNNING = 2'b10
  } ssrs_state_e;
endpackage

// >>> hdl/ssrs_mem_if.sv
// carrier between the sequencer and its register memory
`timescale 1ns/1ps
`default_nettype none
interface ssrs_mem_if #(parameter int AW = 9, parameter int DW = 16);
  logic wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> hdl/ssrs_reg_mem.sv
// backing store for every register address, registered read data
`timescale 1ns/1ps
`default_nettype none
module ssrs_reg_mem #(
  parameter int DEPTH = 512
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // access port
  ssrs_mem_if.mem bus
);
  logic [15:0] store [DEPTH];

  // ----------------------------------------
  // array has no reset; unwritten words read undefined until written
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (bus.wr_en) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus.rdata <= 16'h0000;
    end else begin
      bus.rdata <= store[bus.addr];
    end
  end
endmodule
`default_nettype wire

// >>> test/ssrs_host_model.sv
// host controller model issuing serial register uploads
`timescale 1ns/1ps
`default_nettype none
module ssrs_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic spi_clk,
  output logic cs_n,
  output logic mosi
);
  // serial clock stands low between frames
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one whole frame; each upload ends before the next may start
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [25:0] f;
    f = {wr, a, d};
    q = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      mosi = f[i];
      // four cycles per phase: memory read needs two after the address
      repeat (4) @(negedge clk);
      if (i < 16) q = {q[14:0], miso};
      spi_clk = 1'b1;
      repeat (4) @(negedge clk);
      spi_clk = 1'b0;
    end
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    // released data line must not look like held data
    mosi = ~mosi;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/ssrs_sequencer_properties.sv
// concurrent checks on the ports of the sequencer
`timescale 1ns/1ps
`default_nettype none
module ssrs_sequencer_properties (
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_MISO_OUT,
  input wire logic FRAME_START_IN,
  input wire logic [1:0] SENSOR_STATE_OUT,
  input wire logic SEQ_ENABLE_OUT,
  input wire logic IMAGE_ACTIVE_OUT,
  input wire logic AFE_ENABLE_OUT,
  input wire logic COLUMN_MUX_ENABLE_OUT,
  input wire logic CHARGE_PUMP_ENABLE_OUT,
  input wire logic BIAS_ENABLE_OUT,
  input wire logic LOGIC_CLOCK_ENABLE_OUT,
  input wire logic CORE_SOFT_RESET_OUT,
  input wire logic CLKGEN_SOFT_RESET_OUT,
  input wire logic STATIC_FAULT_OUT,
  input wire logic BLACK_CAL_TRANSIENT_OUT,
  input wire logic SYNC_CODE_TRANSIENT_OUT,
  input wire logic TEST_PATTERN_TRANSIENT_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  logic run;
  logic idle;
  logic powered;
  logic clk_on;
  assign run = SENSOR_STATE_OUT == ssrs_pkg::ST_RUNNING;
  assign idle = SENSOR_STATE_OUT == ssrs_pkg::ST_IDLE;
  assign powered = !CORE_SOFT_RESET_OUT && BIAS_ENABLE_OUT && CHARGE_PUMP_ENABLE_OUT && COLUMN_MUX_ENABLE_OUT
    && AFE_ENABLE_OUT;
  assign clk_on = !CLKGEN_SOFT_RESET_OUT && LOGIC_CLOCK_ENABLE_OUT;
  // state and outputs update on one edge, so each step is judged against the previous state
  sequence s_stop_req;
    $past(run) && !SEQ_ENABLE_OUT && powered && clk_on;
  endsequence
  sequence s_start_req;
    $past(idle) && SEQ_ENABLE_OUT && powered && clk_on;
  endsequence
  a_stop_halts: assert property (s_stop_req |-> idle) else $error("still running after disable");
  a_start_runs: assert property (s_start_req |-> run) else $error("no start after enable");
  a_image_state: assert property (IMAGE_ACTIVE_OUT == run) else $error("image flag disagrees with state");
  a_power_drop: assert property ($past(idle || run) && !powered |-> SENSOR_STATE_OUT == ssrs_pkg::ST_STANDBY)
    else $error("no standby after power down");
  a_clock_stop: assert property ($past(SENSOR_STATE_OUT == ssrs_pkg::ST_STANDBY) && !clk_on |->
    SENSOR_STATE_OUT == ssrs_pkg::ST_CLOCK_OFF) else $error("clock off not reached");
  a_static_run: assert property ($rose(STATIC_FAULT_OUT) |-> $past(IMAGE_ACTIVE_OUT))
    else $error("static fault outside acquisition");
  a_static_clear: assert property (!run [*2] |-> !STATIC_FAULT_OUT) else $error("static fault stuck");
  a_sync_hold: assert property (SYNC_CODE_TRANSIENT_OUT && !FRAME_START_IN |=> SYNC_CODE_TRANSIENT_OUT)
    else $error("sync flag dropped early");
  a_pattern_hold: assert property (TEST_PATTERN_TRANSIENT_OUT && !FRAME_START_IN |=> TEST_PATTERN_TRANSIENT_OUT)
    else $error("pattern flag dropped early");
  a_black_fall: assert property ($fell(BLACK_CAL_TRANSIENT_OUT) |->
    $past(FRAME_START_IN) || $past(FRAME_START_IN, 2)) else $error("black flag fell without frame");
  a_miso_idle: assert property (SPI_CS_N_IN [*3] |-> !SPI_MISO_OUT) else $error("read line busy when idle");
endmodule
bind ssrs_sequencer ssrs_sequencer_properties i_props (.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN),
  .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_MISO_OUT(SPI_MISO_OUT), .FRAME_START_IN(FRAME_START_IN),
  .SENSOR_STATE_OUT(SENSOR_STATE_OUT), .SEQ_ENABLE_OUT(SEQ_ENABLE_OUT), .IMAGE_ACTIVE_OUT(IMAGE_ACTIVE_OUT),
  .AFE_ENABLE_OUT(AFE_ENABLE_OUT), .COLUMN_MUX_ENABLE_OUT(COLUMN_MUX_ENABLE_OUT),
  .CHARGE_PUMP_ENABLE_OUT(CHARGE_PUMP_ENABLE_OUT), .BIAS_ENABLE_OUT(BIAS_ENABLE_OUT),
  .LOGIC_CLOCK_ENABLE_OUT(LOGIC_CLOCK_ENABLE_OUT), .CORE_SOFT_RESET_OUT(CORE_SOFT_RESET_OUT),
  .CLKGEN_SOFT_RESET_OUT(CLKGEN_SOFT_RESET_OUT), .STATIC_FAULT_OUT(STATIC_FAULT_OUT),
  .BLACK_CAL_TRANSIENT_OUT(BLACK_CAL_TRANSIENT_OUT), .SYNC_CODE_TRANSIENT_OUT(SYNC_CODE_TRANSIENT_OUT),
  .TEST_PATTERN_TRANSIENT_OUT(TEST_PATTERN_TRANSIENT_OUT));
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the shutdown and reconfiguration sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fs = 1'b0;
  logic sck, cs_n, mosi, miso, seq, img, txe, afe, cme, cpe, bse, lbe, lce, ple, crst, grst, prst, sf, blk, syn, tp;
  logic [1:0] st;
  logic [5:0] opm;
  logic [5:0] mode;
  logic [1:0] m;
  logic [15:0] q;
  logic [15:0] d;
  logic [8:0] a;
  int error_cnt = 0;
  int tests_run = 0;
  logic [24:0] rv[5] = '{{9'h008, 16'h0099}, {9'h009, 16'h0009}, {9'h00A, 16'h0999}, {9'h020, 16'h2000},
    {9'h048, 16'h0200}};
  logic [24:0] pu[11] = '{{9'h009, 16'h0000}, {9'h020, 16'h200F}, {9'h022, 16'h0001}, {9'h00A, 16'h0000},
    {9'h040, 16'h0001}, {9'h048, 16'h0203}, {9'h028, 16'h0003}, {9'h030, 16'h0001}, {9'h070, 16'h0007},
    {9'h010, 16'h0001}, {9'h008, 16'h0000}};
  logic [24:0] pd[6] = '{{9'h070, 16'h0000}, {9'h030, 16'h0000}, {9'h028, 16'h0000}, {9'h048, 16'h0200},
    {9'h040, 16'h0000}, {9'h00A, 16'h0999}};
  always #10 clk = ~clk;
  ssrs_sequencer i_ssrs_sequencer (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .SPI_CLK_IN(sck), .SPI_CS_N_IN(cs_n),
    .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .FRAME_START_IN(fs), .SENSOR_STATE_OUT(st), .SEQ_ENABLE_OUT(seq),
    .IMAGE_ACTIVE_OUT(img), .OP_MODE_OUT(opm), .TX_ENABLE_OUT(txe), .AFE_ENABLE_OUT(afe),
    .COLUMN_MUX_ENABLE_OUT(cme), .CHARGE_PUMP_ENABLE_OUT(cpe), .BIAS_ENABLE_OUT(bse), .LOGIC_BLOCK_ENABLE_OUT(lbe),
    .LOGIC_CLOCK_ENABLE_OUT(lce), .PLL_ENABLE_OUT(ple), .CORE_SOFT_RESET_OUT(crst), .CLKGEN_SOFT_RESET_OUT(grst),
    .PLL_SOFT_RESET_OUT(prst), .STATIC_FAULT_OUT(sf), .BLACK_CAL_TRANSIENT_OUT(blk),
    .SYNC_CODE_TRANSIENT_OUT(syn), .TEST_PATTERN_TRANSIENT_OUT(tp));
  ssrs_host_model host (.clk(clk), .miso(miso), .spi_clk(sck), .cs_n(cs_n), .mosi(mosi));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] wa, input logic [15:0] wd);
    host.xfer(1'b1, wa, wd, q);
    repeat (2) @(negedge clk);
  endtask
  task automatic pulse();
    @(negedge clk);
    fs = 1'b1;
    @(negedge clk);
    fs = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // logic clock disable value per output mode
  function automatic logic [15:0] clk_off_val(input logic [1:0] sel);
    case (sel)
      2'h0: return 16'h200C;
      2'h1: return 16'h2008;
      2'h2: return 16'h2004;
      default: return 16'h2000;
    endcase
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #800000;
    error_cnt++;
    stop_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h99A8));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    foreach (rv[i]) begin
      host.xfer(1'b0, rv[i][24:16], 16'h0000, q);
      check("reset value", q, rv[i][15:0]);
    end
    check("state after reset", st, ssrs_pkg::ST_CLOCK_OFF);
    $display("done: reset values");
    foreach (pu[i]) wr(pu[i][24:16], pu[i][15:0]);
    repeat (4) @(negedge clk);
    check("state powered", st, ssrs_pkg::ST_IDLE);
    check("enables", {txe, afe, cme, cpe, bse, lbe, lce, ple}, 16'h00FF);
    check("soft resets", {crst, grst, prst}, 16'h0000);
    $display("done: power up");
    mode = 6'($urandom());
    wr(9'h0C0, {9'h000, mode, 1'b1});
    check("state enabled", st, ssrs_pkg::ST_RUNNING);
    check("image active", img, 1'b1);
    check("mode", opm, mode);
    for (int i = 0; i < 4; i++) begin
      a = 9'h0C7 + 9'($urandom_range(5));
      d = 16'($urandom());
      wr(a, d);
      host.xfer(1'b0, a, 16'h0000, q);
      check("dynamic readback", q, d);
      check("dynamic no effect", {st, sf, blk, syn, tp}, 16'h0020);
    end
    $display("done: dynamic writes");
    wr(9'h082, 16'($urandom()));
    check("sync set", {syn, tp}, 16'h0002);
    pulse();
    check("sync cleared", syn, 1'b0);
    wr(9'h092, 16'($urandom()));
    check("pattern set", {syn, tp}, 16'h0001);
    pulse();
    check("pattern cleared", tp, 1'b0);
    wr(9'h080, 16'h460F);
    check("black set", blk, 1'b1);
    repeat (3) pulse();
    check("black settling", blk, 1'b1);
    pulse();
    check("black settled", blk, 1'b0);
    check("still acquiring", img, 1'b1);
    wr(9'h040, 16'h0001);
    check("static fault", {sf, img}, 16'h0003);
    $display("done: reconfiguration while running");
    wr(9'h0C0, {9'h000, mode, 1'b0});
    check("state stopped", st, ssrs_pkg::ST_IDLE);
    check("stopped flags", {img, sf, seq}, 16'h0000);
    check("mode kept", opm, mode);
    $display("done: disable sequencer");
    foreach (pd[i]) wr(pd[i][24:16], pd[i][15:0]);
    check("state standby", st, ssrs_pkg::ST_STANDBY);
    check("enables down", {txe, afe, cme, cpe, bse, lbe, lce, ple}, 16'h0007);
    check("core reset", crst, 1'b1);
    $display("done: soft power down");
    m = 2'($urandom());
    wr(9'h022, 16'h0000);
    wr(9'h020, clk_off_val(m));
    wr(9'h009, 16'h0009);
    check("state clock off", st, ssrs_pkg::ST_CLOCK_OFF);
    check("clock part two", {lbe, lce, grst}, 16'h0001);
    wr(9'h010, 16'h0000);
    wr(9'h008, 16'h0099);
    wr(9'h014, 16'h0000);
    check("pll down", {ple, prst}, 16'h0001);
    host.xfer(1'b0, 9'h020, 16'h0000, q);
    check("clock value", q, clk_off_val(m));
    $display("done: clock shutdown");
    // sensor held in reset while its clock still runs
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
